// ===== sebfe_top.sv
// Two-wire serial EEPROM slave front end with APB control and status.
`timescale 1ns/1ps
`include "sebfe_defs.svh"

module sebfe_top
    import sebfe_pkg::*;
#(
    parameter int PROG_CYCLES = `SEBFE_PROG_TIME_US * `SEBFE_CLK_MHZ
) (
    // Clock and power-on reset.
    input  wire logic        mclk,
    input  wire logic        rst,
    // Two-wire bus pins.
    input  wire logic        scl,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // Strap pins.
    input  wire logic        addr_sel_bit0,
    input  wire logic        addr_sel_bit1,
    input  wire logic        addr_sel_bit2,
    input  wire logic        wp,
    // Power state.
    output logic             standby,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);

    logic [5:0]   pins_s;
    logic         scl_s;
    logic         sda_s;
    logic         wp_s;
    logic [2:0]   asel_s;
    logic         scl_q;
    logic         sda_q;
    logic         scl_rise;
    logic         scl_fall;
    logic         start_c;
    logic         stop_c;
    logic         prot;
    logic         prog_go;

    sebfe_state_t state;
    sebfe_state_t next_state;
    sebfe_phase_t phase;
    sebfe_phase_t next_phase;
    logic [3:0]   bitcnt;
    logic [3:0]   next_bitcnt;
    logic [7:0]   shreg;
    logic [7:0]   next_shreg;
    logic [7:0]   ptr;
    logic [7:0]   next_ptr;
    logic         rd_mode;
    logic         next_rd_mode;
    logic         ack_en;
    logic         next_ack_en;
    logic         pend;
    logic         next_pend;
    logic [3:0]   page;
    logic [3:0]   next_page;
    logic [15:0]  pvalid;
    logic [15:0]  next_pvalid;
    logic         buf_we;

    logic         busy;
    logic         next_busy;
    logic [16:0]  pcnt;
    logic [16:0]  next_pcnt;
    logic         mem_we;
    logic [7:0]   mem_wa;

    logic         ctrl_wp;
    logic         next_ctrl_wp;
    logic [31:0]  next_prdata;
    logic         next_pslverr;

    logic [7:0]   mem [0:`SEBFE_ARRAY_BYTES-1];
    logic [7:0]   pbuf [0:`SEBFE_PAGE_BYTES-1];

    // Every bus and strap pin from outside passes the three-stage filter.
    sebfe_pin_sync #(
        .W       (6),
        .RST_VAL (`SEBFE_SYNC_RST)
    ) u_sync (
        .mclk    (mclk),
        .rst     (rst),
        .pin_in  ({wp, addr_sel_bit2, addr_sel_bit1, addr_sel_bit0, sda_in, scl}),
        .pin_out (pins_s)
    );

    // Unpack the filtered pins; an undriven select pin is pulled to zero on the board.
    assign scl_s  = pins_s[0];
    assign sda_s  = pins_s[1];
    assign asel_s = pins_s[4:2];
    assign wp_s   = pins_s[5];

    // Edges and framing: a data edge while the clock stays high is a start or stop.
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_c  = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_c   = scl_s & scl_q & ~sda_q & sda_s;

    // Protection from the pin or software; grounded pin leaves writes open.
    assign prot    = wp_s | ctrl_wp;
    assign prog_go = stop_c & pend & ~prot & ~busy;

    // Open-drain data pin: only low is ever driven.
    assign sda_out = 1'b0;
    assign sda_oe  = (state == ST_ACK && ack_en) || (state == ST_SEND && !shreg[7]);

    // Standby after reset, after stop, and once programming ends.
    assign standby = (state == ST_IDLE) && !busy;

    // Bit-level receive, acknowledge and transmit sequencing.
    always_comb
    begin
        next_state   = state;
        next_phase   = phase;
        next_bitcnt  = bitcnt;
        next_shreg   = shreg;
        next_ptr     = ptr;
        next_rd_mode = rd_mode;
        next_ack_en  = ack_en;
        next_pend    = pend;
        next_page    = page;
        next_pvalid  = pvalid;
        buf_we       = 1'b0;
        if (start_c)
        begin
            next_state  = ST_RECV;
            next_phase  = PH_DEV;
            next_bitcnt = 4'h0;
        end
        else if (stop_c)
        begin
            next_state  = ST_IDLE;
            next_bitcnt = 4'h0;
            next_pend   = 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    next_bitcnt = 4'h0;
                end
                ST_RECV:
                begin
                    if (scl_rise)
                    begin
                        next_shreg  = {shreg[6:0], sda_s};
                        next_bitcnt = bitcnt + 4'h1;
                    end
                    else if (scl_fall && bitcnt == 4'h8)
                    begin
                        next_bitcnt = 4'h0;
                        next_state  = ST_ACK;
                        next_ack_en = 1'b1;
                        case (phase)
                            PH_DEV:
                            begin
                                if (shreg[7:4] == `SEBFE_DEV_TYPE && shreg[3:1] == asel_s
                                    && !busy)
                                begin
                                    next_rd_mode = shreg[0];
                                    next_phase   = PH_WADDR;
                                end
                                else
                                begin
                                    next_state = ST_IDLE;
                                end
                            end
                            PH_WADDR:
                            begin
                                next_ptr    = shreg;
                                next_pvalid = 16'h0000;
                                next_pend   = 1'b0;
                                next_phase  = PH_DATA;
                            end
                            default:
                            begin
                                buf_we              = 1'b1;
                                next_pvalid[ptr[3:0]] = 1'b1;
                                next_pend           = 1'b1;
                                next_page           = ptr[7:4];
                                next_ptr            = {ptr[7:4], ptr[3:0] + 4'h1};
                            end
                        endcase
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (rd_mode)
                        begin
                            next_shreg = mem[ptr];
                            next_ptr   = ptr + 8'h01;
                            next_state = ST_SEND;
                        end
                        else
                        begin
                            next_state = ST_RECV;
                        end
                    end
                end
                ST_SEND:
                begin
                    if (scl_rise)
                    begin
                        next_bitcnt = bitcnt + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (bitcnt == 4'h8)
                        begin
                            next_state  = ST_MACK;
                            next_bitcnt = 4'h0;
                        end
                        else
                        begin
                            next_shreg = {shreg[6:0], 1'b0};
                        end
                    end
                end
                ST_MACK:
                begin
                    if (scl_rise)
                    begin
                        next_ack_en = ~sda_s;
                    end
                    else if (scl_fall)
                    begin
                        if (ack_en)
                        begin
                            next_shreg = mem[ptr];
                            next_ptr   = ptr + 8'h01;
                            next_state = ST_SEND;
                        end
                        else
                        begin
                            next_state = ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    // Registers of the bit-level sequencer and page buffer.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
            state   <= ST_IDLE;
            phase   <= PH_DEV;
            bitcnt  <= 4'h0;
            shreg   <= 8'h00;
            ptr     <= 8'h00;
            rd_mode <= 1'b0;
            ack_en  <= 1'b0;
            pend    <= 1'b0;
            page    <= 4'h0;
            pvalid  <= 16'h0000;
        end
        else
        begin
            scl_q   <= scl_s;
            sda_q   <= sda_s;
            state   <= next_state;
            phase   <= next_phase;
            bitcnt  <= next_bitcnt;
            shreg   <= next_shreg;
            ptr     <= next_ptr;
            rd_mode <= next_rd_mode;
            ack_en  <= next_ack_en;
            pend    <= next_pend;
            page    <= next_page;
            pvalid  <= next_pvalid;
        end
        if (buf_we)
        begin
            pbuf[ptr[3:0]] <= shreg;
        end
    end

    // Self-timed programming: copy valid buffer bytes, then wait out the cycle.
    always_comb
    begin
        next_busy = busy;
        next_pcnt = pcnt;
        mem_we    = 1'b0;
        mem_wa    = {page, pcnt[3:0]};
        if (prog_go)
        begin
            next_busy = 1'b1;
            next_pcnt = 17'h00000;
        end
        else if (busy)
        begin
            mem_we = (pcnt < 17'(`SEBFE_PAGE_BYTES)) && pvalid[pcnt[3:0]];
            if (pcnt == 17'(PROG_CYCLES - 1))
            begin
                next_busy = 1'b0;
            end
            else
            begin
                next_pcnt = pcnt + 17'h00001;
            end
        end
    end

    // Programming registers and array write port.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            busy <= 1'b0;
            pcnt <= 17'h00000;
        end
        else
        begin
            busy <= next_busy;
            pcnt <= next_pcnt;
        end
        if (mem_we)
        begin
            mem[mem_wa] <= pbuf[pcnt[3:0]];
        end
    end

    // APB decode: one control word, one status word, others flag an error.
    always_comb
    begin
        next_ctrl_wp = ctrl_wp;
        next_prdata  = 32'h00000000;
        next_pslverr = 1'b0;
        if (psel && !penable)
        begin
            if (paddr == `SEBFE_CTRL_OFS)
            begin
                next_prdata[`SEBFE_CTRL_SOFT_WP] = ctrl_wp;
            end
            else if (paddr == `SEBFE_STAT_OFS)
            begin
                next_prdata[`SEBFE_STAT_BUSY]    = busy;
                next_prdata[`SEBFE_STAT_STANDBY] = standby;
                next_prdata[`SEBFE_STAT_PROT]    = prot;
                next_prdata[`SEBFE_STAT_PTR_LO +: 8] = ptr;
            end
            else
            begin
                next_pslverr = 1'b1;
            end
        end
        else if (psel && penable)
        begin
            next_prdata  = prdata;
            next_pslverr = pslverr;
            if (pwrite && paddr == `SEBFE_CTRL_OFS)
            begin
                next_ctrl_wp = pwdata[`SEBFE_CTRL_SOFT_WP];
            end
        end
    end

    // APB registers; the slave answers in the first access cycle.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctrl_wp <= `SEBFE_CTRL_RST;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            ctrl_wp <= next_ctrl_wp;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    assign pready = 1'b1;

    // Checks on the bus behaviour.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_sda_only_low: assert property (sda_oe |-> sda_out == 1'b0)
        else $error("Data pin driven high.");
    a_start_clears: assert property (start_c |=> state == ST_RECV && bitcnt == 4'h0)
        else $error("Start did not restart the receiver.");
    a_stop_to_idle: assert property (stop_c |=> state == ST_IDLE && bitcnt == 4'h0)
        else $error("Stop did not return to idle.");
    a_idle_quiet: assert property (state == ST_IDLE && !start_c |=> state == ST_IDLE)
        else $error("Left idle without a start.");
    a_bit_count: assert property (state == ST_RECV && scl_rise && !start_c && !stop_c
        |=> bitcnt == $past(bitcnt) + 4'h1)
        else $error("Bit not counted on clock rise.");
    a_prot_blocks: assert property ($rose(busy) |-> !$past(prot))
        else $error("Programming began while protected.");
    a_busy_no_ack: assert property (busy && state == ST_RECV && phase == PH_DEV
        |=> !(state == ST_ACK && phase == PH_WADDR))
        else $error("Address acknowledged while programming.");
    a_prog_bound: assert property (pcnt < 17'(PROG_CYCLES))
        else $error("Programming counter passed its limit.");
    a_prog_ends: assert property (busy && pcnt == 17'(PROG_CYCLES - 1) && !prog_go |=> !busy)
        else $error("Programming did not end on time.");
    a_send_stable: assert property (state == ST_SEND && scl_s && $past(scl_s)
        && $past(state) == ST_SEND |-> $stable(sda_oe))
        else $error("Data changed while clock high.");
    a_stop_standby: assert property (stop_c && !busy && !prog_go |=> standby)
        else $error("No standby after stop.");

    c_read_byte: cover property (state == ST_MACK ##1 state == ST_SEND);
    c_prog_start: cover property (prog_go);
    c_prot_write: cover property (stop_c && pend && prot);
    c_busy_nack: cover property (busy && state == ST_RECV ##1 state == ST_IDLE);

endmodule

// ===== sebfe_defs.svh
// Constants for the serial EEPROM bus front end: offsets, fields, resets, timing.
`ifndef SEBFE_DEFS_SVH
`define SEBFE_DEFS_SVH

// Array organisation.
`define SEBFE_ARRAY_BYTES 256
`define SEBFE_PAGE_BYTES  16

// Fixed upper nibble of the slave address byte.
`define SEBFE_DEV_TYPE 4'ha

// Self-timed programming cycle: longest time in microseconds and clock rate.
`define SEBFE_PROG_TIME_US 5000
`define SEBFE_CLK_MHZ      25

// APB register byte offsets.
`define SEBFE_CTRL_OFS 8'h00
`define SEBFE_STAT_OFS 8'h04

// Control register fields and reset value.
`define SEBFE_CTRL_SOFT_WP 0
`define SEBFE_CTRL_RST     1'h0

// Status register fields.
`define SEBFE_STAT_BUSY    0
`define SEBFE_STAT_STANDBY 1
`define SEBFE_STAT_PROT    2
`define SEBFE_STAT_PTR_LO  8

// Idle levels of the synchronised pins: clock and data high, straps low.
`define SEBFE_SYNC_RST 6'h03

`endif

// ===== sebfe_pkg.sv
// Types shared by the serial EEPROM bus front end.
package sebfe_pkg;

    // Bit-level receive and transmit states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RECV,
        ST_ACK,
        ST_SEND,
        ST_MACK
    } sebfe_state_t;

    // Position of the received byte within a command.
    typedef enum logic [1:0] {
        PH_DEV,
        PH_WADDR,
        PH_DATA
    } sebfe_phase_t;

endpackage

// ===== sebfe_pin_sync.sv
// Three-stage pin synchroniser whose output moves once stages two and three agree.
`timescale 1ns/1ps
`include "sebfe_defs.svh"

module sebfe_pin_sync #(
    parameter int         W       = 6,
    parameter logic [5:0] RST_VAL = `SEBFE_SYNC_RST
) (
    // Clock and reset.
    input  wire logic         mclk,
    input  wire logic         rst,
    // Raw pins and filtered levels.
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);

    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] next_out;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            // The output follows only when the two later stages agree.
            always_comb
            begin
                next_out[i] = (ff2[i] == ff3[i]) ? ff3[i] : pin_out[i];
            end

            // The first stage feeds only the second stage.
            always_ff @(posedge mclk)
            begin
                if (rst)
                begin
                    ff1[i]     <= RST_VAL[i];
                    ff2[i]     <= RST_VAL[i];
                    ff3[i]     <= RST_VAL[i];
                    pin_out[i] <= RST_VAL[i];
                end
                else
                begin
                    ff1[i]     <= pin_in[i];
                    ff2[i]     <= ff1[i];
                    ff3[i]     <= ff2[i];
                    pin_out[i] <= next_out[i];
                end
            end
        end
    endgenerate

endmodule

// ===== sebfe_master_model.sv
// Behavioural two-wire bus master that clocks and frames every transfer.
`timescale 1ns/1ps

module sebfe_master_model (
    // System clock that paces the model.
    input  wire logic mclk,
    // Bus lines: wire level in, clock and pull-down out.
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_pull
);
    // The bus idles with the clock high and data released.
    initial
    begin
        scl = 1'h1;
        sda_pull = 1'h0;
    end

    // Waits a number of system clocks.
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Start: data falls while the clock is high; also serves as a repeated start.
    // The longer first wait lets a slave drop its acknowledge before the clock rises.
    task automatic start();
        sda_pull <= 1'h0;
        tick(6);
        scl <= 1'h1;
        tick(4);
        sda_pull <= 1'h1;
        tick(4);
        scl <= 1'h0;
        tick(1);
    endtask

    // Stop: data rises while the clock is high, then the bus idles.
    task automatic stop();
        sda_pull <= 1'h1;
        tick(4);
        scl <= 1'h1;
        tick(4);
        sda_pull <= 1'h0;
        tick(4);
    endtask

    // One bit in a 320 ns pulse; data moves only while the clock is low.
    // Two clocks high and six low, so a slave that answers five clocks late still moves
    // its data before the clock rises again.
    task automatic xfer(input logic b, output logic r);
        sda_pull <= ~b;
        tick(5);
        scl <= 1'h1;
        tick(2);
        r = sda_line;
        scl <= 1'h0;
        tick(1);
    endtask

    // Sends a byte most significant bit first and returns the acknowledge.
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            xfer(d[i], r);
        xfer(1'h1, r);
        ack = ~r;
    endtask

    // Receives a byte and acknowledges it when asked.
    task automatic get(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            xfer(1'h1, r);
            d[i] = r;
        end
        xfer(~ack, r);
    endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the serial EEPROM bus front end.
`timescale 1ns/1ps
`include "sebfe_defs.svh"

module testbench;
    localparam int PROG = 200;
    typedef struct {
        logic        wr;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] mask;
        logic [31:0] exp;
        logic        err;
    } sebfe_row_t;
    // Clock, reset, pins and APB.
    logic        mclk, rst, scl, sda_pull, sda_out, sda_oe, sda, wp, standby;
    logic [2:0]  sel;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    int          n_mismatch, checks_done;
    sebfe_row_t  rows [10] = '{
        '{1'h0, `SEBFE_CTRL_OFS, 32'h0, 32'hffffffff, 32'h0, 1'h0},
        '{1'h1, `SEBFE_CTRL_OFS, 32'h1, 32'h0, 32'h0, 1'h0},
        '{1'h0, `SEBFE_CTRL_OFS, 32'h0, 32'hffffffff, 32'h1, 1'h0},
        '{1'h0, `SEBFE_STAT_OFS, 32'h0, 32'hffffffff, 32'h6, 1'h0},
        '{1'h1, `SEBFE_STAT_OFS, 32'h0, 32'h0, 32'h0, 1'h0},
        '{1'h0, `SEBFE_STAT_OFS, 32'h0, 32'hffffffff, 32'h6, 1'h0},
        '{1'h1, `SEBFE_CTRL_OFS, 32'h0, 32'h0, 32'h0, 1'h0},
        '{1'h0, `SEBFE_STAT_OFS, 32'h0, 32'hffffffff, 32'h2, 1'h0},
        '{1'h0, 8'h08, 32'h0, 32'hffffffff, 32'h0, 1'h1},
        '{1'h1, 8'h0c, 32'h1, 32'h0, 32'h0, 1'h1}
    };

    // Open-drain data wire with pull-up.
    assign sda = (sda_oe ? sda_out : 1'h1) & ~sda_pull;

    sebfe_top #(.PROG_CYCLES(PROG)) i_dut (
        .mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_sel_bit0(sel[0]), .addr_sel_bit1(sel[1]), .addr_sel_bit2(sel[2]), .wp(wp),
        .standby(standby), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );
    sebfe_master_model i_master (.mclk(mclk), .sda_line(sda), .scl(scl), .sda_pull(sda_pull));

    // 25 MHz clock.
    initial
    begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_word(what, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic results();
        $display("TB: %0d checks, %0d mismatches", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One APB transfer: setup, then access held until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'h1 && n < 8);
        if (n == 8)
        begin
            n_mismatch++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // Polls status until programming ends, within one and a half times the self-timed bound.
    task automatic prog_wait(input logic busy);
        logic [31:0] rd;
        logic err;
        int n;
        apb(1'h0, `SEBFE_STAT_OFS, 32'h0, rd, err);
        chk_bit("busy", busy, rd[`SEBFE_STAT_BUSY]);
        chk_bit("standby", ~busy, standby);
        for (n = 0; rd[`SEBFE_STAT_BUSY] !== 1'h0 && n < PROG / 2; n++)
            apb(1'h0, `SEBFE_STAT_OFS, 32'h0, rd, err);
        chk_bit("prog end", 1'h1, n < PROG / 2);
        if (n == PROG / 2)
            results();
    endtask

    // Write sequence; when programming should start, an address poll must go unanswered.
    task automatic eep_write(input logic [7:0] wa, input logic [7:0] d[$], input logic prog);
        logic ack;
        i_master.start();
        i_master.put({`SEBFE_DEV_TYPE, sel, 1'h0}, ack);
        chk_bit("dev ack", 1'h1, ack);
        i_master.put(wa, ack);
        chk_bit("word ack", 1'h1, ack);
        foreach (d[i])
        begin
            i_master.put(d[i], ack);
            chk_bit("data ack", 1'h1, ack);
        end
        i_master.stop();
        if (prog)
        begin
            i_master.start();
            i_master.put({`SEBFE_DEV_TYPE, sel, 1'h0}, ack);
            chk_bit("busy ack", 1'h0, ack);
            i_master.stop();
        end
        prog_wait(prog);
    endtask

    // Random read, then sequential bytes acknowledged except the last.
    task automatic eep_read(input logic [7:0] wa, input logic [7:0] e[$]);
        logic ack;
        logic [7:0] d;
        i_master.start();
        i_master.put({`SEBFE_DEV_TYPE, sel, 1'h0}, ack);
        i_master.put(wa, ack);
        i_master.start();
        i_master.put({`SEBFE_DEV_TYPE, sel, 1'h1}, ack);
        chk_bit("read ack", 1'h1, ack);
        foreach (e[i])
        begin
            i_master.get(i < e.size() - 1, d);
            chk_word("read data", {24'h0, e[i]}, {24'h0, d});
        end
        i_master.stop();
    endtask

    // Cuts a hang short.
    initial
    begin
        repeat (90000) @(posedge mclk);
        n_mismatch++;
        results();
    end

    // Main sequence: register rows, then the bus scenarios.
    initial
    begin
        logic [31:0] rd;
        logic err, ack, b;
        {rst, psel, penable, pwrite, paddr, pwdata, sel, wp} = {1'h1, 47'h0};
        {n_mismatch, checks_done} = 0;
        repeat (12) @(posedge mclk);
        rst <= 1'h0;
        repeat (4) @(posedge mclk);
        chk_bit("standby", 1'h1, standby);
        chk_bit("sda_out", 1'h0, sda_out);
        foreach (rows[i])
        begin
            apb(rows[i].wr, rows[i].a, rows[i].d, rd, err);
            if (!rows[i].wr)
                chk_word("reg data", rows[i].exp, rd & rows[i].mask);
            chk_bit("reg err", rows[i].err, err);
        end
        $display("TB: registers done");
        for (int s = 0; s < 8; s++)
        begin
            sel <= s[2:0];
            repeat (4) @(posedge mclk);
            i_master.start();
            i_master.put({`SEBFE_DEV_TYPE, s[2:0] ^ 3'h5, 1'h1}, ack);
            chk_bit("foreign ack", 1'h0, ack);
            i_master.start();
            // A dummy write: the array is still blank, so nothing is read back here.
            i_master.put({`SEBFE_DEV_TYPE, s[2:0], 1'h0}, ack);
            chk_bit("own ack", 1'h1, ack);
            i_master.stop();
        end
        $display("TB: address select done");
        eep_write(8'h1d, '{8'h5a}, 1'h1);
        eep_write(8'h1e, '{8'h11, 8'h22, 8'h33}, 1'h1);
        eep_read(8'h1d, '{8'h5a, 8'h11, 8'h22});
        eep_read(8'h10, '{8'h33});
        $display("TB: page write done");
        wp <= 1'h1;
        eep_write(8'h1d, '{8'hff}, 1'h0);
        wp <= 1'h0;
        apb(1'h1, `SEBFE_CTRL_OFS, 32'h1, rd, err);
        eep_write(8'h10, '{8'hee}, 1'h0);
        apb(1'h1, `SEBFE_CTRL_OFS, 32'h0, rd, err);
        eep_read(8'h1d, '{8'h5a});
        eep_read(8'h10, '{8'h33});
        $display("TB: protection done");
        i_master.put({`SEBFE_DEV_TYPE, sel, 1'h0}, ack);
        chk_bit("no start ack", 1'h0, ack);
        i_master.start();
        repeat (3) i_master.xfer(1'h1, b);
        i_master.stop();
        i_master.start();
        repeat (3) i_master.xfer(1'h1, b);
        i_master.start();
        i_master.put({`SEBFE_DEV_TYPE, sel, 1'h0}, ack);
        chk_bit("restart ack", 1'h1, ack);
        i_master.stop();
        $display("TB: framing done");
        i_master.start();
        // Reset strikes while the slave still holds its acknowledge low.
        i_master.put({`SEBFE_DEV_TYPE, sel, 1'h0}, ack);
        rst <= 1'h1;
        repeat (4) @(posedge mclk);
        chk_bit("reset oe", 1'h0, sda_oe);
        chk_bit("reset standby", 1'h1, standby);
        rst <= 1'h0;
        i_master.stop();
        eep_read(8'h1d, '{8'h5a});
        $display("TB: reset done");
        results();
    end
endmodule
